// [cpsc_pkg.sv]
// shared constants for the cpu side control glue
package cpsc_pkg;
  localparam logic [7:0] CPSC_PORT_NMI = 8'h70;
  localparam logic [7:0] CPSC_PORT_COPRO_CLR = 8'hf0;
  localparam logic [7:0] CPSC_PORT_RESET_RD = 8'hef;
  localparam int CPSC_NMI_MASK_BIT = 7;
  localparam logic CPSC_NMI_MASK_RESET = 1'b1;
  // cycle type codes on {mem_io, data_code, write_read}
  localparam logic [2:0] CPSC_CYC_HALT_SHUT = 3'h2;
  localparam int CPSC_RESET_PULSE_CYC = 16;
  localparam int CPSC_CLK_HZ = 10000000;
  typedef enum logic [1:0] {
    CPSC_CLK_DIV1, CPSC_CLK_DIV2, CPSC_CLK_DIV3, CPSC_CLK_DIV4
  } cpsc_busclk_e;
endpackage

// [cpsc_if.sv]
// cpu side pins between the controller and the processor
`timescale 1ns/100ps
interface cpsc_if;
  logic holdRequest;
  logic holdGrant;
  logic cpuIrq;
  logic nmiOut;
  logic cpuExtRequest;
  logic cycleDoneN;
  logic cpuResetOut;
  logic [2:0] cycTypeCpu;
  logic [2:0] cycTypeDev;
  logic cycTypeDevOeN;
  logic [2:0] cycType;
  // no pull-up here: cycType reads the cpu value whenever the device does not enable its drive
  assign cycType = !cycTypeDevOeN ? cycTypeDev : cycTypeCpu;
  modport dev (
    output holdRequest, cpuIrq, nmiOut, cpuExtRequest, cycleDoneN,
    output cpuResetOut, cycTypeDev, cycTypeDevOeN,
    input holdGrant, cycType
  );
  modport cpu (
    input holdRequest, cpuIrq, nmiOut, cpuExtRequest, cycleDoneN,
    input cpuResetOut, cycType,
    output holdGrant, cycTypeCpu
  );
endinterface

// [cpsc_cpu_end.sv]
// processor end: hold handshake and cycle type drive
`timescale 1ns/100ps
module cpsc_cpu_end (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pins
  cpsc_if.cpu pins,
  // user side
  input wire logic [2:0] cycTypeReq,
  output logic floated,
  output logic irqSeen,
  output logic nmiSeen,
  output logic extReqSeen,
  output logic readySeen,
  output logic inReset
);
  import cpsc_pkg::*;
  logic grant_ff, nxt_grant;
  logic [4:0] obs_ff, nxt_obs;
  always_comb begin
    // grant and floated outputs in the same cycle, one cycle after request
    nxt_grant = pins.holdRequest && !pins.cpuResetOut;
    nxt_obs = {pins.cpuIrq, pins.nmiOut, pins.cpuExtRequest,
               !pins.cycleDoneN, pins.cpuResetOut};
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      grant_ff <= 1'b0;
      obs_ff <= 5'h0;
    end else begin
      grant_ff <= nxt_grant;
      obs_ff <= nxt_obs;
    end
  end
  assign pins.holdGrant = grant_ff;
  // floated while granted: pins go to pull-up level
  assign pins.cycTypeCpu = grant_ff ? 3'h7 : cycTypeReq;
  assign floated = grant_ff;
  assign irqSeen = obs_ff[4];
  assign nmiSeen = obs_ff[3];
  assign extReqSeen = obs_ff[2];
  // the board ors ready sources; this end sees the single source
  assign readySeen = obs_ff[1];
  assign inReset = obs_ff[0];
endmodule

// [cpsc_dev_end.sv]
// controller end: hold, interrupt, nmi, coprocessor, ready and reset glue
`timescale 1ns/100ps
// How it works
// - strap pins chosen bus clock at reset
// - processor floats its outputs in the same cycle it grants hold
// - hold request high while master needs bus
// - irq follows interrupt controller request
// - cycle pins carry channel code in dma
// - nmi on parity or channel error, enabled
// - nmi disabled at reset, port 70h bit7
// - extension request follows coprocessor request
// - error after busy release forces request
// - write to F0h releases forced request
// - ready from dram or synced channel ready
// - board ors ready with other agents
// - reset on port A bit or EFh read
// - reset on power fail, shutdown, synchronous
module cpsc_dev_end #(
  parameter int RESET_CYC = cpsc_pkg::CPSC_RESET_PULSE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pins
  cpsc_if.dev pins,
  // straps
  input wire logic dma_ack_decoder_en_n,
  input wire logic peripheral_port_select_n,
  // internal masters
  input wire logic masterNeedsBus,
  input wire logic dmaAckCycle,
  input wire logic [2:0] dmaChanCode,
  input wire logic picRequest,
  // error sources
  input wire logic parityErr,
  input wire logic channelErr,
  // coprocessor
  input wire logic copro_operand_request,
  input wire logic copro_error_n,
  input wire logic copro_busy_n,
  // cycle end sources
  input wire logic dramDone,
  input wire logic slotCycle,
  input wire logic channel_ready_in,
  // i/o port access from the cpu decode
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [7:0] ioAddr,
  input wire logic [7:0] ioData,
  input wire logic portAResetBit,
  input wire logic supply_ok_in,
  // status
  output cpsc_pkg::cpsc_busclk_e slot_bus_clock,
  output logic busOwned
);
  import cpsc_pkg::*;
  logic hold_ff, nxt_hold;
  logic own_ff, nxt_own;
  logic irq_ff, nxt_irq;
  logic nmiMask_ff, nxt_nmiMask;
  logic nmi_ff, nxt_nmi;
  logic busyPrev_ff, nxt_busyPrev;
  logic armed_ff, nxt_armed;
  logic forced_ff, nxt_forced;
  logic ext_ff, nxt_ext;
  logic chRdyS1_ff, chRdyS2_ff;
  logic doneN_ff, nxt_doneN;
  logic [7:0] rstCnt_ff, nxt_rstCnt;
  logic rst_ff, nxt_rst;
  logic strapDone_ff, nxt_strapDone;
  cpsc_busclk_e clk_ff, nxt_clk;
  logic [2:0] code_ff, nxt_code;
  logic codeOeN_ff, nxt_codeOeN;
  logic resetReq;

  function automatic logic ioHit(input logic [7:0] a, input logic [7:0] p);
    ioHit = a == p;
  endfunction

  always_comb begin
    // strap caught once on the first cycle after release
    nxt_strapDone = 1'b1;
    nxt_clk = clk_ff;
    if (!strapDone_ff) begin
      nxt_clk = cpsc_busclk_e'({dma_ack_decoder_en_n,
                                peripheral_port_select_n});
    end
    // request held while the master wants the bus
    nxt_hold = masterNeedsBus;
    // drive only while granted and still requesting
    nxt_own = hold_ff && pins.holdGrant && masterNeedsBus;
    nxt_codeOeN = !(own_ff && dmaAckCycle);
    nxt_code = dmaChanCode;
    nxt_irq = picRequest;
    nxt_nmiMask = nmiMask_ff;
    if (ioWrite && ioHit(ioAddr, CPSC_PORT_NMI)) begin
      nxt_nmiMask = ioData[CPSC_NMI_MASK_BIT];
    end
    nxt_nmi = !nmiMask_ff && (parityErr || channelErr);
    nxt_busyPrev = copro_busy_n;
    nxt_armed = armed_ff;
    nxt_forced = forced_ff;
    if (ioWrite && ioHit(ioAddr, CPSC_PORT_COPRO_CLR)) begin
      nxt_forced = 1'b0;
      nxt_armed = 1'b0;
    end
    // arming on busy release beats a clear in the same cycle
    if (!busyPrev_ff && copro_busy_n) begin
      nxt_armed = 1'b1;
    end
    // set wins over the release in the same cycle
    if (armed_ff && copro_busy_n && !copro_error_n) begin
      nxt_forced = 1'b1;
    end
    nxt_ext = nxt_forced || copro_operand_request;
    // ready: dram done, or synchronised channel ready on slot cycles
    nxt_doneN = !(dramDone || (slotCycle && chRdyS2_ff));
    // shutdown only counts while the processor drives the cycle pins
    resetReq = portAResetBit || !supply_ok_in ||
               (ioRead && ioHit(ioAddr, CPSC_PORT_RESET_RD)) ||
               (codeOeN_ff && pins.cycType == CPSC_CYC_HALT_SHUT);
    // stretch every source by RESET_CYC-1 cycles past its end on the clock
    nxt_rstCnt = rstCnt_ff;
    if (resetReq) begin
      nxt_rstCnt = 8'(RESET_CYC);
    end else if (rstCnt_ff != 8'h0) begin
      nxt_rstCnt = rstCnt_ff - 8'h1;
    end
    nxt_rst = resetReq || rstCnt_ff > 8'h1;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hold_ff <= 1'b0;
      own_ff <= 1'b0;
      irq_ff <= 1'b0;
      nmiMask_ff <= CPSC_NMI_MASK_RESET;
      nmi_ff <= 1'b0;
      busyPrev_ff <= 1'b1;
      armed_ff <= 1'b0;
      forced_ff <= 1'b0;
      ext_ff <= 1'b0;
      chRdyS1_ff <= 1'b0;
      chRdyS2_ff <= 1'b0;
      doneN_ff <= 1'b1;
      rstCnt_ff <= 8'h0;
      rst_ff <= 1'b1;
      strapDone_ff <= 1'b0;
      clk_ff <= CPSC_CLK_DIV1;
      code_ff <= 3'h7;
      codeOeN_ff <= 1'b1;
    end else begin
      hold_ff <= nxt_hold;
      own_ff <= nxt_own;
      irq_ff <= nxt_irq;
      nmiMask_ff <= nxt_nmiMask;
      nmi_ff <= nxt_nmi;
      busyPrev_ff <= nxt_busyPrev;
      armed_ff <= nxt_armed;
      forced_ff <= nxt_forced;
      ext_ff <= nxt_ext;
      chRdyS1_ff <= channel_ready_in;
      chRdyS2_ff <= chRdyS1_ff;
      doneN_ff <= nxt_doneN;
      rstCnt_ff <= nxt_rstCnt;
      rst_ff <= nxt_rst;
      strapDone_ff <= nxt_strapDone;
      clk_ff <= nxt_clk;
      code_ff <= nxt_code;
      codeOeN_ff <= nxt_codeOeN;
    end
  end

  assign pins.holdRequest = hold_ff;
  assign pins.cpuIrq = irq_ff;
  assign pins.nmiOut = nmi_ff;
  assign pins.cpuExtRequest = ext_ff;
  assign pins.cycleDoneN = doneN_ff;
  assign pins.cpuResetOut = rst_ff;
  assign pins.cycTypeDev = code_ff;
  assign pins.cycTypeDevOeN = codeOeN_ff;
  assign slot_bus_clock = clk_ff;
  assign busOwned = own_ff;
endmodule

// [cpsc_properties.sv]
// assertions on the cpu side pins
`timescale 1ns/100ps
module cpsc_properties (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pins
  input wire logic holdRequest,
  input wire logic holdGrant,
  input wire logic cpuIrq,
  input wire logic nmiOut,
  input wire logic cpuExtRequest,
  input wire logic cpuResetOut,
  input wire logic cycTypeDevOeN,
  input wire logic [2:0] cycType
);
  import cpsc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_grant_after_req: assert property (
    $rose(holdGrant) |-> $past(holdRequest)) else $error("early grant");
  a_grant_drops: assert property (
    $fell(holdRequest) |=> !holdGrant) else $error("grant kept");
  a_code_when_owned: assert property (
    !cycTypeDevOeN |-> $past(holdGrant, 2)) else $error("code unowned");
  a_code_released: assert property (
    $fell(holdGrant) |-> ##2 cycTypeDevOeN) else $error("code kept");
  a_shutdown_reset: assert property (
    cycTypeDevOeN && cycType == CPSC_CYC_HALT_SHUT |-> ##[1:2] cpuResetOut)
    else $error("no shutdown reset");
  a_reset_stretch: assert property (
    $rose(cpuResetOut) |=> cpuResetOut) else $error("short reset");
  a_nmi_off_reset: assert property (
    $rose(reset_n) |-> !nmiOut) else $error("nmi after reset");
  a_idle_after_reset: assert property (
    $rose(reset_n) |-> !(holdRequest || cpuIrq || cpuExtRequest))
    else $error("outputs after reset");
  cover property (holdGrant && !cycTypeDevOeN);
  cover property ($rose(nmiOut));
  cover property ($rose(cpuResetOut));
endmodule

// [cpu_side_control_signals_tb.sv]
// self-checking bench for both ends of the cpu side glue
`timescale 1ns/100ps
module cpu_side_control_signals_tb;
  import cpsc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic dkenN, ppicsN, needBus, dmaAck, pic, parErr, chanErr, opReq, errN;
  logic busyN, dram, slot, chRdy, ioWr, ioRd, portA, supOk, owned;
  logic floated, irqSeen, nmiSeen, extReqSeen, readySeen, inReset;
  logic [2:0] chanCode, cycReq;
  logic [7:0] ioAddr, ioData;
  logic [5:0] q[$];
  logic [5:0] expd, seen;
  logic [1:0] strap;
  logic [11:0] rdyH;
  cpsc_busclk_e busClk;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  cpsc_if pinsIf();
  cpsc_dev_end #(.RESET_CYC(2)) cpsc_dev_end_inst (.clk(clk),
    .reset_n(reset_n), .pins(pinsIf), .dma_ack_decoder_en_n(dkenN),
    .peripheral_port_select_n(ppicsN), .masterNeedsBus(needBus),
    .dmaAckCycle(dmaAck), .dmaChanCode(chanCode), .picRequest(pic),
    .parityErr(parErr), .channelErr(chanErr), .copro_operand_request(opReq),
    .copro_error_n(errN), .copro_busy_n(busyN), .dramDone(dram),
    .slotCycle(slot), .channel_ready_in(chRdy), .ioWrite(ioWr),
    .ioRead(ioRd), .ioAddr(ioAddr), .ioData(ioData), .portAResetBit(portA),
    .supply_ok_in(supOk), .slot_bus_clock(busClk), .busOwned(owned));
  cpsc_cpu_end cpsc_cpu_end_inst (.clk(clk), .reset_n(reset_n),
    .pins(pinsIf), .cycTypeReq(cycReq), .floated(floated),
    .irqSeen(irqSeen), .nmiSeen(nmiSeen), .extReqSeen(extReqSeen),
    .readySeen(readySeen), .inReset(inReset));
  cpsc_properties cpsc_properties_inst (.clk(clk), .reset_n(reset_n),
    .holdRequest(pinsIf.holdRequest), .holdGrant(pinsIf.holdGrant),
    .cpuIrq(pinsIf.cpuIrq), .nmiOut(pinsIf.nmiOut),
    .cpuExtRequest(pinsIf.cpuExtRequest), .cpuResetOut(pinsIf.cpuResetOut),
    .cycTypeDevOeN(pinsIf.cycTypeDevOeN), .cycType(pinsIf.cycType));
  initial forever #50 clk = ~clk;
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // expectation order {owned, floated, irq, nmi, ext, reset}
  task automatic chk(input int n, input logic [4:0] e,
      input logic o = 1'b0);
    repeat (n) @(posedge clk);
    q.push_back({o, e});
  endtask
  // bus clock must keep the strap value caught after reset
  task automatic chk_clk();
    total_checks++;
    if (busClk !== cpsc_busclk_e'(strap)) begin
      n_errors++;
      $display("[FAIL] %0t bus clock %0d", $time, busClk);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    ioRd <= 1'b1;
    ioAddr <= a;
    @(posedge clk);
    ioRd <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    ioWr <= 1'b1;
    ioAddr <= a;
    ioData <= d;
    @(posedge clk);
    ioWr <= 1'b0;
  endtask
  always @(negedge clk) begin
    seen = {owned, floated, irqSeen, nmiSeen, extReqSeen, inReset};
    if (q.size() > 0) begin
      expd = q.pop_front();
      total_checks++;
      if (seen !== expd) begin
        n_errors++;
        $display("[FAIL] %0t seen %b expected %b", $time, seen, expd);
      end
    end
    // ready seen two edges after dram, four after channel ready
    if (cycles >= 8) begin
      total_checks++;
      if (readySeen !== (rdyH[5] || (rdyH[4] && rdyH[9]))) begin
        n_errors++;
        $display("[FAIL] %0t ready %b", $time, readySeen);
      end
    end
  end
  // ready sources toggle at random; they must not disturb other pins
  always @(posedge clk) begin
    cycles++;
    dram <= 1'($urandom);
    slot <= 1'($urandom);
    chRdy <= 1'($urandom);
    rdyH <= {rdyH[8:0], dram, slot, chRdy};
    if (cycles == 1000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    {needBus, dmaAck, pic, parErr, chanErr, opReq, ioWr, ioRd, portA} = '0;
    {errN, busyN, supOk} = '1;
    {dkenN, ppicsN} = 2'($urandom(2810));
    strap = {dkenN, ppicsN};
    {chanCode, ioAddr, ioData} = '0;
    cycReq = 3'h5;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    chk(4, 5'h00);
    chk_clk();
    {dkenN, ppicsN} <= ~strap;
    needBus <= 1'b1;
    dmaAck <= 1'b1;
    chanCode <= 3'($urandom);
    chk(6, 5'h10, 1'b1);
    needBus <= 1'b0;
    dmaAck <= 1'b0;
    chk(6, 5'h00);
    pic <= 1'b1;
    chk(4, 5'h08);
    pic <= 1'b0;
    parErr <= 1'b1;
    chk(6, 5'h00);
    wr(CPSC_PORT_NMI, {1'b0, 7'($urandom)});
    chk(4, 5'h04);
    parErr <= 1'b0;
    chanErr <= 1'b1;
    chk(4, 5'h04);
    wr(CPSC_PORT_NMI, {1'b1, 7'($urandom)});
    chk(4, 5'h00);
    chanErr <= 1'b0;
    opReq <= 1'b1;
    chk(4, 5'h02);
    opReq <= 1'b0;
    busyN <= 1'b0;
    chk(4, 5'h00);
    busyN <= 1'b1;
    chk(2, 5'h00);
    errN <= 1'b0;
    chk(4, 5'h02);
    errN <= 1'b1;
    chk(4, 5'h02);
    wr(CPSC_PORT_COPRO_CLR, 8'($urandom));
    chk(4, 5'h00);
    portA <= 1'b1;
    chk(6, 5'h01);
    portA <= 1'b0;
    chk(8, 5'h00);
    rd(CPSC_PORT_NMI);
    chk(4, 5'h00);
    rd(CPSC_PORT_RESET_RD);
    chk(2, 5'h01);
    chk(4, 5'h00);
    cycReq <= CPSC_CYC_HALT_SHUT;
    chk(6, 5'h01);
    cycReq <= 3'h5;
    chk(8, 5'h00);
    supOk <= 1'b0;
    chk(6, 5'h01);
    supOk <= 1'b1;
    chk(8, 5'h00);
    chk_clk();
    // let the last queued note be compared before closing
    repeat (2) @(negedge clk);
    if (q.size() != 0) begin
      n_errors++;
      $display("[FAIL] %0t %0d notes unchecked", $time, q.size());
    end
    close_out();
  end
endmodule
